// [design/dpd_counter.sv]
// delayed pulse generator and frequency divider counter channel
`timescale 1ns/1ps
module dpd_counter
    import dpd_pkg::*;
#(
    parameter int CNT_W = CNT_W_DEF
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    output logic [31:0] rd_data_out,
    input wire logic src_pin_in,
    input wire logic gate_pin_in,
    output logic cnt_out
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] at_least_one(input logic [CNT_W-1:0] v);
        at_least_one = (v == '0) ? CNT_W'(1) : v;
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        reg_hit = (a == off);
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_q;
    logic [CNT_W-1:0] delay_length_q;
    logic [CNT_W-1:0] pulse_length_q;
    logic [CNT_W-1:0] divide_ratio_q;
    logic [CNT_W-1:0] count_q;
    dpd_state_type state_q;
    logic phase_q;
    logic tc_pulse_q;
    logic tog_q;
    logic ovf_q;
    logic out_q;
    logic out_d;
    logic func_div;
    logic src_sel;
    logic edge_fall;
    logic pol_low;
    dpd_gate_type gate_mode;
    dpd_outb_type outb;
    logic start_command;
    logic stop_command;
    logic clr_ovf;
    logic read_command;
    logic src_lvl;
    logic src_rise;
    logic src_fall;
    logic gate_lvl;
    logic gate_rise;
    logic gate_fall;
    logic tb_rise;
    logic tb_fall;
    logic tick;
    logic gate_edge;
    logic edge_mode;
    logic restart_mode;
    logic gate_ok;
    logic retrig;
    logic count_en;
    logic terminal_count;
    logic [CNT_W-1:0] delay_load;
    logic [CNT_W-1:0] pulse_load;
    logic [CNT_W-1:0] div_load;
    logic [CNT_W-1:0] first_load;

    // ------------------------------------------------------------
    // pin synchronisers and timebase
    // ------------------------------------------------------------
    dpd_sync_edge u_src_sync (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .pin_in(src_pin_in),
        .level_out(src_lvl),
        .rise_out(src_rise),
        .fall_out(src_fall)
    );

    dpd_sync_edge u_gate_sync (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .pin_in(gate_pin_in),
        .level_out(gate_lvl),
        .rise_out(gate_rise),
        .fall_out(gate_fall)
    );

    dpd_timebase u_timebase (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .slow_sel_in(ctrl_q[CTRL_TBSEL_BIT]),
        .rise_out(tb_rise),
        .fall_out(tb_fall)
    );

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    assign start_command = wr_strobe_in && reg_hit(addr_in, OFF_CMD) && wr_data_in[CMD_START_BIT];
    assign stop_command = wr_strobe_in && reg_hit(addr_in, OFF_CMD) && wr_data_in[CMD_STOP_BIT];
    assign clr_ovf = wr_strobe_in && reg_hit(addr_in, OFF_CMD) && wr_data_in[CMD_CLROVF_BIT];
    assign read_command = rd_strobe_in && reg_hit(addr_in, OFF_COUNT);

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ctrl_q <= CTRL_RST;
            delay_length_q <= '0;
            pulse_length_q <= '0;
            divide_ratio_q <= '0;
        end else if (wr_strobe_in) begin
            if (reg_hit(addr_in, OFF_CTRL)) begin
                ctrl_q <= wr_data_in[CTRL_W-1:0];
            end
            if (reg_hit(addr_in, OFF_DELAY)) begin
                delay_length_q <= wr_data_in[CNT_W-1:0];
            end
            if (reg_hit(addr_in, OFF_PULSE)) begin
                pulse_length_q <= wr_data_in[CNT_W-1:0];
            end
            if (reg_hit(addr_in, OFF_DIVIDE)) begin
                divide_ratio_q <= wr_data_in[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rd_data_out <= 32'h00000000;
        end else if (rd_strobe_in) begin
            rd_data_out <= 32'h00000000;
            case (addr_in)
                OFF_CTRL: rd_data_out[CTRL_W-1:0] <= ctrl_q;
                OFF_DELAY: rd_data_out[CNT_W-1:0] <= delay_length_q;
                OFF_PULSE: rd_data_out[CNT_W-1:0] <= pulse_length_q;
                OFF_DIVIDE: rd_data_out[CNT_W-1:0] <= divide_ratio_q;
                OFF_STATUS: rd_data_out[5:0] <= {ovf_q, tog_q, out_q, phase_q, state_q};
                OFF_COUNT: begin
                    rd_data_out[CNT_W-1:0] <= count_q;
                    rd_data_out[COUNT_OVF_BIT] <= ovf_q;
                end
                default: rd_data_out <= 32'h00000000;
            endcase
        end else begin
            rd_data_out <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    assign func_div = ctrl_q[CTRL_FUNC_BIT];
    assign src_sel = ctrl_q[CTRL_SRC_BIT];
    assign edge_fall = ctrl_q[CTRL_EDGE_BIT];
    assign pol_low = ctrl_q[CTRL_POL_BIT];
    assign gate_mode = dpd_gate_type'(ctrl_q[CTRL_GATE_HI:CTRL_GATE_LO]);
    assign outb = dpd_outb_type'(ctrl_q[CTRL_OUTB_HI:CTRL_OUTB_LO]);

    // counted clock: chosen source, chosen edge
    assign tick = src_sel ? (edge_fall ? src_fall : src_rise)
                          : (edge_fall ? tb_fall : tb_rise);

    assign restart_mode = (gate_mode == GATE_RESTART_RISE) || (gate_mode == GATE_RESTART_FALL);
    assign edge_mode = restart_mode || (gate_mode == GATE_START_RISE)
                       || (gate_mode == GATE_START_FALL);
    assign gate_edge = ((gate_mode == GATE_START_RISE) || (gate_mode == GATE_RESTART_RISE))
                       ? gate_rise : gate_fall;

    always_comb begin
        case (gate_mode)
            GATE_COUNT_HIGH: gate_ok = gate_lvl;
            GATE_COUNT_LOW: gate_ok = ~gate_lvl;
            default: gate_ok = 1'b1;
        endcase
    end

    assign delay_load = (!src_sel && delay_length_q == '0) ? CNT_W'(MIN_DELAY_TICKS)
                        : at_least_one(delay_length_q);
    assign pulse_load = at_least_one(pulse_length_q);
    assign div_load = at_least_one(divide_ratio_q);
    assign first_load = func_div ? div_load : delay_load;

    assign retrig = edge_mode && gate_edge
                    && ((state_q == ST_ARMED) || (state_q == ST_RUN && restart_mode));
    assign count_en = (state_q == ST_RUN) && tick && gate_ok && !retrig;
    assign terminal_count = count_en && (count_q <= CNT_W'(1));

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_q <= ST_IDLE;
            count_q <= '0;
            phase_q <= 1'b0;
        end else if (stop_command) begin
            state_q <= ST_IDLE;
        end else if (start_command) begin
            count_q <= first_load;
            phase_q <= 1'b0;
            state_q <= edge_mode ? ST_ARMED : ST_RUN;
        end else if (retrig) begin
            count_q <= first_load;
            phase_q <= 1'b0;
            state_q <= ST_RUN;
        end else if (count_en) begin
            if (terminal_count) begin
                if (func_div) begin
                    count_q <= div_load;
                end else if (!phase_q) begin
                    phase_q <= 1'b1;
                    count_q <= pulse_load;
                end else begin
                    phase_q <= 1'b0;
                    count_q <= '0;
                    state_q <= restart_mode ? ST_ARMED : ST_IDLE;
                end
            end else begin
                count_q <= count_q - CNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // divider terminal count output
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || stop_command || start_command) begin
            tc_pulse_q <= 1'b0;
            tog_q <= 1'b0;
        end else if (terminal_count && func_div) begin
            tc_pulse_q <= 1'b1;
            tog_q <= ~tog_q;
        end else if (tick) begin
            tc_pulse_q <= 1'b0;
        end
    end

    // overflow: set on each divider rollover, set wins over clear
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ovf_q <= 1'b0;
        end else if (terminal_count && func_div) begin
            ovf_q <= 1'b1;
        end else if (clr_ovf || start_command) begin
            ovf_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // output pin
    // ------------------------------------------------------------
    always_comb begin
        if (func_div) begin
            case (outb)
                OUT_HIGH_PULSE: out_d = tc_pulse_q;
                OUT_LOW_PULSE: out_d = ~tc_pulse_q;
                OUT_HIGH_TOGGLE: out_d = tog_q;
                OUT_LOW_TOGGLE: out_d = ~tog_q;
                default: out_d = 1'b0;
            endcase
        end else if (state_q == ST_RUN && phase_q) begin
            out_d = ~pol_low;
        end else begin
            out_d = pol_low;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            out_q <= 1'b0;
        end else begin
            out_q <= out_d;
        end
    end

    assign cnt_out = out_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence seq_start_ungated;
        start_command && !stop_command && gate_mode == GATE_IGNORED_SW_START;
    endsequence

    sequence seq_running_free;
        state_q == ST_RUN && !wr_strobe_in;
    endsequence

    a_stop_halts: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        stop_command |=> state_q == ST_IDLE && $stable(count_q))
        else $error("stop did not halt the counter");

    a_ungated_start: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        seq_start_ungated |=> state_q == ST_RUN)
        else $error("ungated start did not run");

    a_zero_delay_min: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        start_command && !stop_command && !func_div && !src_sel && delay_length_q == '0
        |=> count_q == CNT_W'(MIN_DELAY_TICKS) && !phase_q)
        else $error("zero delay not stretched to three ticks");

    a_pos_delay_low: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !func_div && !pol_low && !(state_q == ST_RUN && phase_q) |=> !out_q)
        else $error("high polarity output not low outside pulse");

    a_neg_pulse_low: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !func_div && pol_low && state_q == ST_RUN && phase_q |=> !out_q)
        else $error("low polarity pulse phase not low");

    a_gate_high_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        seq_running_free and (gate_mode == GATE_COUNT_HIGH && !gate_lvl)
        |=> $stable(count_q) && $stable(phase_q))
        else $error("counted while gate low in level-high mode");

    a_gate_low_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        seq_running_free and (gate_mode == GATE_COUNT_LOW && gate_lvl)
        |=> $stable(count_q) && $stable(phase_q))
        else $error("counted while gate high in level-low mode");

    a_edge_wait: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        state_q == ST_ARMED && !gate_edge && !wr_strobe_in |=> state_q == ST_ARMED)
        else $error("armed counter left without gate edge");

    a_retrig_reload: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        state_q == ST_RUN && restart_mode && gate_edge && !wr_strobe_in
        |=> count_q == $past(first_load) && !phase_q)
        else $error("gate edge did not restart the sequence");

    a_div_pulse_one: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        terminal_count && func_div && !wr_strobe_in ##1 (!tick && !wr_strobe_in)[*2]
        |-> tc_pulse_q)
        else $error("divider pulse ended before next tick");

    a_div_toggle: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        terminal_count && func_div && !wr_strobe_in |=> tog_q != $past(tog_q))
        else $error("divider output did not toggle");

    a_read_count: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        read_command |=> rd_data_out[COUNT_OVF_BIT] == $past(ovf_q)
                         && rd_data_out[CNT_W-1:0] == $past(count_q))
        else $error("count read returned wrong data");
endmodule

// [design/dpd_pkg.sv]
// constants and types shared by the delayed pulse and divider counter
package dpd_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DELAY = 8'h04;
    localparam logic [7:0] OFF_PULSE = 8'h08;
    localparam logic [7:0] OFF_DIVIDE = 8'h0C;
    localparam logic [7:0] OFF_CMD = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_COUNT = 8'h18;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_W = 10;
    localparam int CTRL_FUNC_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int CTRL_TBSEL_BIT = 2;
    localparam int CTRL_EDGE_BIT = 3;
    localparam int CTRL_POL_BIT = 4;
    localparam int CTRL_GATE_LO = 5;
    localparam int CTRL_GATE_HI = 7;
    localparam int CTRL_OUTB_LO = 8;
    localparam int CTRL_OUTB_HI = 9;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int CMD_CLROVF_BIT = 2;
    localparam int COUNT_OVF_BIT = 31;

    // ------------------------------------------------------------
    // reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [9:0] CTRL_RST = 10'h000;
    localparam int CNT_W_DEF = 24;
    localparam int CLK_HZ = 100000000;
    localparam int TB_FAST_HZ = 20000000;
    localparam int TB_SLOW_HZ = 100000;
    localparam int TB_FAST_DIV = CLK_HZ / TB_FAST_HZ;
    localparam int TB_SLOW_DIV = CLK_HZ / TB_SLOW_HZ;
    localparam int MIN_DELAY_TICKS = 3;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        GATE_IGNORED_SW_START = 3'b000,
        GATE_COUNT_HIGH = 3'b001,
        GATE_COUNT_LOW = 3'b010,
        GATE_START_RISE = 3'b011,
        GATE_START_FALL = 3'b100,
        GATE_RESTART_RISE = 3'b101,
        GATE_RESTART_FALL = 3'b110
    } dpd_gate_type;

    typedef enum logic [1:0] {
        OUT_HIGH_PULSE = 2'b00,
        OUT_LOW_PULSE = 2'b01,
        OUT_HIGH_TOGGLE = 2'b10,
        OUT_LOW_TOGGLE = 2'b11
    } dpd_outb_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN = 2'b10
    } dpd_state_type;

endpackage

// [design/dpd_sync_edge.sv]
// two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ps
module dpd_sync_edge (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic pin_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign level_out = s2_q;
    assign rise_out = s2_q & ~s3_q;
    assign fall_out = ~s2_q & s3_q;
endmodule

// [design/dpd_timebase.sv]
// internal timebase: one of two fixed rates, as rise and fall pulses
`timescale 1ns/1ps
module dpd_timebase
    import dpd_pkg::*;
#(
    parameter int FAST_DIV = TB_FAST_DIV,
    parameter int SLOW_DIV = TB_SLOW_DIV
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic slow_sel_in,
    output logic rise_out,
    output logic fall_out
);
    localparam int DW = $clog2(SLOW_DIV + 1);
    logic [DW-1:0] div_cnt_q;
    logic [DW-1:0] top;
    logic [DW-1:0] half;

    assign top = slow_sel_in ? DW'(SLOW_DIV - 1) : DW'(FAST_DIV - 1);
    assign half = slow_sel_in ? DW'(SLOW_DIV / 2) : DW'(FAST_DIV / 2);

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || div_cnt_q >= top) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + DW'(1);
        end
    end

    // one clock of each pulse per timebase period
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rise_out <= 1'b0;
            fall_out <= 1'b0;
        end else begin
            rise_out <= (div_cnt_q == '0);
            fall_out <= (div_cnt_q == half);
        end
    end
endmodule

// [tb/dpd_pins_model.sv]
// outside wiring model: source pin pulse train and gate pin
`timescale 1ns/1ps
module dpd_pins_model (
    input wire logic mclk_in,
    input wire logic gate_level_in,
    output logic src_out,
    output logic gate_out
);
    initial src_out = 1'b0;
    // gate pin is always driven, so gated modes never see a floating gate
    assign gate_out = gate_level_in;
    // each source cycle is 4 clocks high, 4 low: well below mclk/4 and wide enough to sync
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge mclk_in);
            src_out <= 1'b1;
            repeat (4) @(posedge mclk_in);
            src_out <= 1'b0;
            repeat (3) @(posedge mclk_in);
        end
    endtask
endmodule

// [tb/dpd_counter_tb_top.sv]
// self-checking bench for the delayed pulse and divider counter
`timescale 1ns/1ps
module dpd_counter_tb_top;
    import dpd_pkg::*;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wr_data_in = 32'h0;
    logic wr_strobe_in = 1'b0;
    logic rd_strobe_in = 1'b0;
    logic [31:0] rd_data_out;
    logic src_pin, gate_pin, cnt_out, prev_out;
    logic gate_level = 1'b0;
    int failures = 0;
    int n_tests = 0;
    int rises = 0;
    int changes = 0;
    logic [31:0] v;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} dpd_row_type;
    dpd_row_type rows [6] = '{
        '{OFF_STATUS, 32'hFFFFFFFF, 32'h00000000}, '{8'h1C, 32'hFFFFFFFF, 32'h00000000},
        '{OFF_DELAY, 32'hFFFFFFFF, 32'h00FFFFFF}, '{OFF_PULSE, 32'h12345678, 32'h00345678},
        '{OFF_DIVIDE, 32'h00000ABC, 32'h00000ABC}, '{OFF_CTRL, 32'h00000CA5, 32'h000000A5}};

    always #5 mclk_in = ~mclk_in;

    dpd_counter DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
        .rd_data_out(rd_data_out), .src_pin_in(src_pin), .gate_pin_in(gate_pin),
        .cnt_out(cnt_out));
    dpd_pins_model u_pins (.mclk_in(mclk_in), .gate_level_in(gate_level), .src_out(src_pin),
        .gate_out(gate_pin));

    // ------------------------------------------------------------
    // output edge monitor
    // ------------------------------------------------------------
    always @(posedge mclk_in) begin
        prev_out <= cnt_out;
        if (prev_out === 1'b0 && cnt_out === 1'b1) rises <= rises + 1;
        if (prev_out !== cnt_out) changes <= changes + 1;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_strobe_in <= 1'b1;
        @(posedge mclk_in);
        wr_strobe_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        rd_strobe_in <= 1'b1;
        @(posedge mclk_in);
        rd_strobe_in <= 1'b0;
        #1 d = rd_data_out;
    endtask
    task automatic edges(input int n);
        u_pins.pulses(n);
        repeat (5) @(posedge mclk_in);
    endtask
    task automatic setup(input logic [31:0] ctrl, input logic [31:0] dly, input logic [31:0] pw);
        wr(OFF_CMD, 32'h2);
        wr(OFF_CTRL, ctrl);
        wr(OFF_DELAY, dly);
        wr(OFF_PULSE, pw);
        wr(OFF_DIVIDE, pw);
        repeat (4) @(posedge mclk_in);
        rises = 0;
        changes = 0;
        wr(OFF_CMD, 32'h1);
    endtask
    // waits for the output to go high, then counts the clocks it stays high
    task automatic high_len(output logic [31:0] n);
        n = 0;
        repeat (1100) begin
            @(posedge mclk_in);
            if (cnt_out === 1'b1) break;
        end
        while (cnt_out === 1'b1 && n < 1100) begin
            @(posedge mclk_in);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        finish_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk("register row", rows[i].e, v);
        end
        $display("register rows done");
        @(posedge mclk_in);
        sys_rst_in <= 1'b1;
        repeat (6) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        rd(OFF_CTRL, v);
        chk("ctrl reset", 32'h0, v);
        rd(OFF_DELAY, v);
        chk("delay reset", 32'h0, v);
        chk("out at reset", 32'h0, {31'h0, cnt_out});
        $display("reset test done");
        // delayed pulse on source pin, pulse_active_high, ungated
        setup(32'h002, 32'h2, 32'h2);
        edges(1);
        chk("delay phase low", 32'h0, {31'h0, cnt_out});
        edges(1);
        chk("pulse phase high", 32'h1, {31'h0, cnt_out});
        edges(1);
        chk("pulse still high", 32'h1, {31'h0, cnt_out});
        edges(1);
        chk("rest after pulse", 32'h0, {31'h0, cnt_out});
        // pulse_active_low
        setup(32'h012, 32'h1, 32'h1);
        chk("rest high", 32'h1, {31'h0, cnt_out});
        edges(1);
        chk("neg pulse low", 32'h0, {31'h0, cnt_out});
        edges(1);
        chk("neg rest high", 32'h1, {31'h0, cnt_out});
        $display("polarity test done");
        // divider, pulsed, then toggled, then toggled on falling edges
        setup(32'h003, 32'h0, 32'h3);
        edges(6);
        chk("pulse count", 32'd2, rises);
        rd(OFF_COUNT, v);
        chk("overflow flag", 32'h1, {31'h0, v[COUNT_OVF_BIT]});
        setup(32'h203, 32'h0, 32'h3);
        edges(6);
        chk("toggle count", 32'd2, changes);
        setup(32'h20B, 32'h0, 32'h3);
        edges(3);
        chk("falling toggles", 32'd1, changes);
        setup(32'h10B, 32'h0, 32'h2);
        edges(3);
        chk("low pulse", 32'd1, rises);
        $display("divider test done");
        // level-high gating, then stop
        setup(32'h022, 32'h1, 32'h5);
        edges(3);
        chk("gate low holds", 32'h0, {31'h0, cnt_out});
        gate_level <= 1'b1;
        repeat (5) @(posedge mclk_in);
        edges(1);
        chk("gate high counts", 32'h1, {31'h0, cnt_out});
        wr(OFF_CMD, 32'h2);
        repeat (3) @(posedge mclk_in);
        chk("stop rest", 32'h0, {31'h0, cnt_out});
        rd(OFF_STATUS, v);
        chk("stop idle", 32'h0, {30'h0, v[1:0]});
        // edge start on gate rise
        gate_level <= 1'b0;
        setup(32'h062, 32'h1, 32'h5);
        edges(2);
        chk("waits for edge", 32'h0, {31'h0, cnt_out});
        gate_level <= 1'b1;
        repeat (6) @(posedge mclk_in);
        edges(1);
        chk("edge started", 32'h1, {31'h0, cnt_out});
        // level-low gating, gate still high
        setup(32'h042, 32'h1, 32'h5);
        edges(2);
        chk("gate high holds", 32'h0, {31'h0, cnt_out});
        gate_level <= 1'b0;
        repeat (5) @(posedge mclk_in);
        edges(1);
        chk("gate low counts", 32'h1, {31'h0, cnt_out});
        // restart on each rising gate edge
        setup(32'h0A2, 32'h2, 32'h5);
        gate_level <= 1'b1;
        repeat (6) @(posedge mclk_in);
        edges(1);
        gate_level <= 1'b0;
        repeat (5) @(posedge mclk_in);
        gate_level <= 1'b1;
        repeat (6) @(posedge mclk_in);
        edges(1);
        chk("retrigger reloads", 32'h0, {31'h0, cnt_out});
        edges(1);
        chk("retrigger pulse", 32'h1, {31'h0, cnt_out});
        $display("gate test done");
        // zero delay on the fast internal timebase: three ticks before the pulse
        setup(32'h000, 32'h0, 32'h1);
        v = 0;
        while (cnt_out !== 1'b1 && v < 40) begin
            @(posedge mclk_in);
            v++;
        end
        chk("min delay", 32'h1, {31'h0, (v > 2 * TB_FAST_DIV + 2) && (v <= 3 * TB_FAST_DIV + 2)});
        chk("pulse after min delay", 32'h1, {31'h0, cnt_out});
        // divider on the fast timebase: pulse lasts one timebase period
        setup(32'h001, 32'h0, 32'h2);
        high_len(v);
        chk("timebase divider pulse", TB_FAST_DIV, v);
        // slow timebase: one-tick pulse lasts one slow period
        setup(32'h004, 32'h1, 32'h1);
        high_len(v);
        chk("slow pulse width", TB_SLOW_DIV, v);
        $display("timebase test done");
        finish_test();
    end
endmodule
